// ---- rtl/bsl_link.sv ----
// slave end of the binary serial command link: receiver, interpreter, transmitter
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module bsl_link
    import bsl_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYC,
    parameter int DEV_N = 64
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic rxd,
    input wire logic hs_ok,
    input wire bsl_cfg_s cfg_nv,
    input wire logic [DEV_N-1:0] dev_bits,
    input wire logic [MAP_MAX-1:0] fb_bits,
    input wire logic [MAP_MAX-1:0][15:0] fb_words,
    output logic txd,
    output logic run_mode,
    output bsl_wr_s wr,
    output bsl_cfg_s cfg_act
);
    // -------------------------------------------------------------------------
    // settings capture
    // -------------------------------------------------------------------------
    // settings are sampled once after reset release so later edits wait for a power cycle
    logic cfg_pend_ff;
    bsl_cfg_s cfg_ff;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_pend_ff <= 1'b1;
            cfg_ff <= '{station: STATION_RST, mem: MEM_NONE};
        end else if (cfg_pend_ff) begin
            cfg_pend_ff <= 1'b0;
            cfg_ff <= cfg_nv;
        end
    end
    assign cfg_act = cfg_ff;

    // -------------------------------------------------------------------------
    // receiver
    // -------------------------------------------------------------------------
    localparam logic [CNT_W-1:0] BIT_LD = CNT_W'(BIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] HALF_LD = CNT_W'(BIT_CYCLES / 2);
    bsl_rx_e rx_st_ff;
    logic [CNT_W-1:0] rx_cnt_ff;
    logic [3:0] rx_bit_ff;
    logic [7:0] rx_sh_ff;
    logic byte_vld_ff;
    // rxd is taken as synchronous to clk_sys, so no synchroniser sits in front of it
    wire rx_tick = (rx_cnt_ff == '0);
    wire [7:0] rx_shift = {rxd, rx_sh_ff[7:1]};
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_st_ff <= RX_IDLE;
            rx_cnt_ff <= '0;
            rx_bit_ff <= '0;
            rx_sh_ff <= '0;
            byte_vld_ff <= 1'b0;
        end else begin
            byte_vld_ff <= 1'b0;
            rx_cnt_ff <= rx_tick ? BIT_LD : rx_cnt_ff - 1'b1;
            case (rx_st_ff)
                RX_IDLE: begin
                    rx_cnt_ff <= HALF_LD;
                    if (!rxd && hs_ok && !cfg_pend_ff) rx_st_ff <= RX_START;
                end
                RX_START: if (rx_tick) begin
                    rx_st_ff <= rxd ? RX_IDLE : RX_DATA;
                    rx_bit_ff <= '0;
                end
                RX_DATA: if (rx_tick) begin
                    rx_sh_ff <= rx_shift;
                    rx_bit_ff <= rx_bit_ff + 1'b1;
                    if (rx_bit_ff == LAST_BIT) rx_st_ff <= RX_STOP;
                end
                RX_STOP: if (rx_tick) begin
                    rx_st_ff <= RX_IDLE;
                    byte_vld_ff <= rxd && hs_ok; // a framing error drops the byte
                end
                default: rx_st_ff <= RX_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // frame assembly and decode
    // -------------------------------------------------------------------------
    logic [7:0] fr_ff [FRAME_LEN];
    logic [2:0] fr_idx_ff;
    logic tx_busy_ff;
    wire first_ok = (fr_idx_ff != IX_STX) || (rx_sh_ff == STX);
    wire frame_end = byte_vld_ff && (fr_idx_ff == IX_ETX);
    // the station byte is checked though only one host is attached
    wire frame_ok = frame_end && (rx_sh_ff == ETX) && !tx_busy_ff
                    && (fr_ff[IX_STN] == {4'h0, cfg_ff.station});
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fr_idx_ff <= IX_STX;
        end else if (byte_vld_ff) begin
            fr_idx_ff <= (frame_end || !first_ok) ? IX_STX : fr_idx_ff + 1'b1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (byte_vld_ff) fr_ff[fr_idx_ff] <= rx_sh_ff;
    end

    wire [7:0] cmd = fr_ff[IX_CMD];
    wire [7:0] adr = fr_ff[IX_ADR];
    wire [15:0] wdat = {fr_ff[IX_DHI], fr_ff[IX_DLO]};
    wire [7:0] map_lim = (cfg_ff.mem == MEM_50) ? MAP_50 :
                         (cfg_ff.mem == MEM_100) ? MAP_100 : MAP_0;
    wire in_map = adr < map_lim;
    wire in_dev = adr < 8'(DEV_N);
    wire [6:0] mix = in_map ? adr[6:0] : 7'h00;
    wire is_fb = (cmd == CMD_RD_FBB) || (cmd == CMD_WR_FBB)
                 || (cmd == CMD_RD_FBW) || (cmd == CMD_WR_FBW);
    wire is_dev = (cmd == CMD_RD_DEV) || (cmd == CMD_WR_DEV);
    wire is_wr = (cmd == CMD_WR_DEV) || (cmd == CMD_WR_FBB)
                 || (cmd == CMD_WR_FBW) || (cmd == CMD_TS_SET);
    wire known = is_fb || is_dev || (cmd == CMD_TS_SET);
    wire acc_err = !known || (is_fb && !in_map) || (is_dev && !in_dev);
    wire [15:0] bit_dev = {15'h0000, in_dev ? dev_bits[adr[5:0]] : 1'b0};
    wire [15:0] bit_fb = {15'h0000, fb_bits[mix]};
    wire [15:0] rd_val = acc_err ? 16'h0000 :
                         (cmd == CMD_RD_DEV) ? bit_dev :
                         (cmd == CMD_RD_FBB) ? bit_fb :
                         (cmd == CMD_RD_FBW) ? fb_words[mix] : wdat;

    // -------------------------------------------------------------------------
    // reply build and action
    // -------------------------------------------------------------------------
    logic [7:0] tx_buf_ff [FRAME_LEN];
    logic [2:0] tx_len_ff;
    logic tx_go_ff;
    logic run_ff;
    bsl_wr_s wr_ff;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_go_ff <= 1'b0;
            tx_len_ff <= '0;
            run_ff <= 1'b0;
            wr_ff <= '0;
        end else begin
            tx_go_ff <= frame_ok;
            wr_ff.stb <= frame_ok && (cmd != CMD_LINE) && (cmd != CMD_RUNSTOP)
                         && is_wr && !acc_err;
            if (frame_ok) begin
                wr_ff.cmd <= cmd;
                wr_ff.addr <= adr;
                wr_ff.data <= wdat;
                if (cmd == CMD_RUNSTOP) begin
                    // bit 0 of the low data byte selects run (1) or stop (0)
                    run_ff <= fr_ff[IX_DLO][0];
                    tx_len_ff <= LEN_RS;
                end else begin
                    tx_len_ff <= LEN_FULL;
                end
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (frame_ok) begin
            if (cmd == CMD_RUNSTOP) begin
                tx_buf_ff[0] <= STX;
                tx_buf_ff[1] <= FLAG_DONE;
                tx_buf_ff[2] <= STX;
                tx_buf_ff[3] <= ACK;
            end else if (cmd == CMD_LINE) begin
                for (int i = 0; i < FRAME_LEN - 1; i++) tx_buf_ff[i] <= fr_ff[i];
                tx_buf_ff[IX_ETX] <= ETX;
            end else begin
                tx_buf_ff[IX_STX] <= STX;
                tx_buf_ff[IX_STN] <= fr_ff[IX_STN];
                tx_buf_ff[IX_CMD] <= acc_err ? (cmd | ERR_MARK) : cmd;
                tx_buf_ff[IX_ADR] <= adr;
                tx_buf_ff[IX_DHI] <= rd_val[15:8];
                tx_buf_ff[IX_DLO] <= rd_val[7:0];
                tx_buf_ff[IX_ETX] <= ETX;
            end
        end
    end
    assign run_mode = run_ff;
    assign wr = wr_ff;

    // -------------------------------------------------------------------------
    // transmitter
    // -------------------------------------------------------------------------
    localparam logic [3:0] TX_BITS = 4'(1 + DATA_BITS + STOP_BITS);
    logic [CNT_W-1:0] tx_cnt_ff;
    logic [3:0] tx_bit_ff;
    logic [2:0] tx_byte_ff;
    logic [9:0] tx_sh_ff;
    logic txd_ff;
    wire tx_tick = (tx_cnt_ff == '0);
    wire tx_last_bit = (tx_bit_ff == TX_BITS - 1'b1);
    wire tx_last_byte = (tx_byte_ff == tx_len_ff - 1'b1);
    // the next character loads at the stop bit's last tick, so reply bytes run back to back
    wire [9:0] next_chr = {1'b1, tx_buf_ff[tx_byte_ff + 1'b1], 1'b0};
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_busy_ff <= 1'b0;
            tx_cnt_ff <= '0;
            tx_bit_ff <= '0;
            tx_byte_ff <= '0;
            tx_sh_ff <= '1;
            txd_ff <= 1'b1;
        end else if (tx_go_ff) begin
            tx_busy_ff <= 1'b1;
            tx_cnt_ff <= BIT_LD;
            tx_bit_ff <= '0;
            tx_byte_ff <= '0;
            tx_sh_ff <= {1'b1, tx_buf_ff[0], 1'b0};
            txd_ff <= 1'b0;
        end else if (tx_busy_ff) begin
            tx_cnt_ff <= tx_tick ? BIT_LD : tx_cnt_ff - 1'b1;
            if (tx_tick) begin
                if (!tx_last_bit) begin
                    tx_bit_ff <= tx_bit_ff + 1'b1;
                    txd_ff <= tx_sh_ff[tx_bit_ff + 1'b1];
                end else if (tx_last_byte) begin
                    tx_busy_ff <= 1'b0;
                    txd_ff <= 1'b1;
                end else begin
                    tx_bit_ff <= '0;
                    tx_byte_ff <= tx_byte_ff + 1'b1;
                    tx_sh_ff <= next_chr;
                    txd_ff <= 1'b0;
                end
            end
        end
    end
    assign txd = txd_ff;

    // -------------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    reply_cause_a: assert property ($rose(tx_busy_ff) |-> $past(frame_ok, 2))
        else $error("reply started without a host frame");
    idle_line_a: assert property (!tx_busy_ff && !tx_go_ff |=> txd)
        else $error("line not idle high");
    start_bit_a: assert property (tx_go_ff |=> !txd [*2])
        else $error("start bit missing");
    hs_block_a: assert property (!hs_ok && rx_st_ff == RX_IDLE |=> rx_st_ff == RX_IDLE)
        else $error("receive began without handshake");
    runstop_reply_a: assert property (frame_ok && cmd == CMD_RUNSTOP
        |=> tx_len_ff == LEN_RS && tx_buf_ff[0] == STX && tx_buf_ff[1] == FLAG_DONE
        && tx_buf_ff[2] == STX && tx_buf_ff[3] == ACK)
        else $error("bad run/stop reply");
    line_echo_a: assert property (frame_ok && cmd == CMD_LINE
        |=> tx_buf_ff[IX_CMD] == CMD_LINE && tx_buf_ff[IX_STX] == STX && tx_buf_ff[IX_ETX] == ETX)
        else $error("line check not echoed");
    zero_map_a: assert property (cfg_ff.mem == MEM_NONE && frame_ok && is_fb
        |=> !wr_ff.stb && tx_buf_ff[IX_CMD][7])
        else $error("mapped data reached with zero memory");
    fb_bit_a: assert property (frame_ok && cmd == CMD_RD_FBB && in_map
        |=> tx_buf_ff[IX_DLO][0] == $past(fb_bits[adr[6:0]]))
        else $error("mapped bit value wrong");
    settings_hold_a: assert property (!cfg_pend_ff |=> $stable(cfg_ff))
        else $error("settings changed without power cycle");
    station_match_a: assert property (frame_ok |-> fr_ff[IX_STN][3:0] == cfg_ff.station)
        else $error("foreign station accepted");
    fb_word_a: assert property (frame_ok && cmd == CMD_RD_FBW && in_map
        |=> {tx_buf_ff[IX_DHI], tx_buf_ff[IX_DLO]} == $past(fb_words[adr[6:0]]))
        else $error("mapped word value wrong");
    map_limit_a: assert property (frame_ok && is_fb
        && adr >= ((cfg_ff.mem == MEM_50) ? MAP_50 : MAP_100)
        |=> !wr_ff.stb && tx_buf_ff[IX_CMD][7])
        else $error("access beyond communication memory");
    stb_pulse_a: assert property (wr_ff.stb |=> !wr_ff.stb)
        else $error("write strobe longer than one cycle");
    run_select_a: assert property (frame_ok && cmd == CMD_RUNSTOP
        |=> run_mode == $past(fr_ff[IX_DLO][0]))
        else $error("run/stop request not applied");

    // -------------------------------------------------------------------------
    // cover points
    // -------------------------------------------------------------------------
    line_c: cover property (frame_ok && cmd == CMD_LINE ##1 tx_busy_ff [*8]);
    runstop_c: cover property (frame_ok && cmd == CMD_RUNSTOP);
    fbw_c: cover property (frame_ok && cmd == CMD_RD_FBW && in_map);
    wr_c: cover property (wr_ff.stb && wr_ff.cmd == CMD_TS_SET);
    err_c: cover property (frame_ok && acc_err && is_fb);
endmodule : bsl_link
`default_nettype wire

// ---- rtl/bsl_pkg.sv ----
// constants, commands and carrier types of the binary serial slave link
package bsl_pkg;
    // -------------------------------------------------------------------------
    // serial framing
    // -------------------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int BAUD = 9600;
    localparam int BIT_CYC = CLK_HZ / BAUD;
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 1;
    localparam int CNT_W = 16;
    localparam logic [3:0] LAST_BIT = 4'h7;
    // -------------------------------------------------------------------------
    // control characters and frame layout
    // -------------------------------------------------------------------------
    localparam logic [7:0] STX = 8'h02;
    localparam logic [7:0] ETX = 8'h03;
    localparam logic [7:0] ACK = 8'h06;
    localparam logic [7:0] ERR_MARK = 8'h80;
    localparam logic [7:0] FLAG_DONE = 8'h01;
    localparam int FRAME_LEN = 7;
    localparam logic [2:0] IX_STX = 3'h0;
    localparam logic [2:0] IX_STN = 3'h1;
    localparam logic [2:0] IX_CMD = 3'h2;
    localparam logic [2:0] IX_ADR = 3'h3;
    localparam logic [2:0] IX_DHI = 3'h4;
    localparam logic [2:0] IX_DLO = 3'h5;
    localparam logic [2:0] IX_ETX = 3'h6;
    localparam logic [2:0] LEN_FULL = 3'h7;
    localparam logic [2:0] LEN_RS = 3'h4;
    // -------------------------------------------------------------------------
    // commands
    // -------------------------------------------------------------------------
    localparam logic [7:0] CMD_LINE = 8'h00;
    localparam logic [7:0] CMD_RD_DEV = 8'h01;
    localparam logic [7:0] CMD_WR_DEV = 8'h02;
    localparam logic [7:0] CMD_RD_FBB = 8'h03;
    localparam logic [7:0] CMD_WR_FBB = 8'h04;
    localparam logic [7:0] CMD_RD_FBW = 8'h05;
    localparam logic [7:0] CMD_WR_FBW = 8'h06;
    localparam logic [7:0] CMD_RUNSTOP = 8'h07;
    localparam logic [7:0] CMD_TS_SET = 8'h08;
    // -------------------------------------------------------------------------
    // communication memory
    // -------------------------------------------------------------------------
    localparam int MAP_MAX = 100;
    localparam logic [7:0] MAP_0 = 8'h00;
    localparam logic [7:0] MAP_50 = 8'h32;
    localparam logic [7:0] MAP_100 = 8'h64;
    localparam logic [3:0] STATION_RST = 4'h0;
    typedef enum logic [1:0] {MEM_NONE, MEM_50, MEM_100, MEM_RSV} bsl_mem_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} bsl_rx_e;
    typedef struct packed {
        logic [3:0] station;
        bsl_mem_e mem;
    } bsl_cfg_s;
    typedef struct packed {
        logic stb;
        logic [7:0] cmd;
        logic [7:0] addr;
        logic [15:0] data;
    } bsl_wr_s;
endpackage : bsl_pkg

// ---- test/bsl_host_model.sv ----
// host master model of the serial link: sends request frames, collects reply bytes
`timescale 1ns/10ps
`default_nettype none
module bsl_host_model #(
    parameter int BITC = 16
) (
    input wire logic clk_sys,
    input wire logic txd,
    output var logic rxd,
    output var logic hs_ok
);
    logic [7:0] rx_q[$];
    logic [7:0] rx_b;
    // idle line high, the one handshake line high except while the bench drives hs_ok low
    initial begin
        rxd = 1'b1;
        hs_ok = 1'b1;
    end
    // -------------------------------------------------------------------------
    // request side: called at a falling edge, one host, one controller
    // -------------------------------------------------------------------------
    task automatic send_byte(input logic [7:0] b);
        rxd = 1'b0;
        repeat (BITC) @(negedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            rxd = b[i];
            repeat (BITC) @(negedge clk_sys);
        end
        rxd = 1'b1;
        repeat (BITC) @(negedge clk_sys);
    endtask : send_byte
    task automatic send_frame(input logic [7:0] stn, cmd, adr, hi, lo);
        send_byte(8'h02);
        send_byte(stn);
        send_byte(cmd);
        send_byte(adr);
        send_byte(hi);
        send_byte(lo);
        send_byte(8'h03);
    endtask : send_frame
    // -------------------------------------------------------------------------
    // reply side: sample each bit in its middle
    // -------------------------------------------------------------------------
    always begin
        @(negedge txd);
        repeat (BITC / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (BITC) @(posedge clk_sys);
            rx_b[i] = txd;
        end
        repeat (BITC) @(posedge clk_sys);
        rx_q.push_back(rx_b);
    end
endmodule : bsl_host_model
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking bench of the serial slave link against the host master model
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import bsl_pkg::*;
;
    localparam int BITC = 16;
    logic clk_sys, rst_n, rxd, hs_ok, txd, run_mode;
    bsl_cfg_s cfg_nv, cfg_act, cur;
    logic [63:0] dev_bits;
    logic [MAP_MAX-1:0] fb_bits;
    logic [MAP_MAX-1:0][15:0] fb_words;
    bsl_wr_s wr;
    logic [7:0] exp_q[$];
    logic [15:0] corners[4] = '{16'h0531, 16'h0532, 16'h013f, 16'h0240};
    int num_errors = 0;
    int check_count = 0;
    int stb_cnt = 0;
    bsl_host_model #(.BITC(BITC)) host (.clk_sys(clk_sys), .txd(txd), .rxd(rxd), .hs_ok(hs_ok));
    bsl_link #(.BIT_CYCLES(BITC), .DEV_N(64)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .rxd(rxd),
        .hs_ok(hs_ok), .cfg_nv(cfg_nv), .dev_bits(dev_bits), .fb_bits(fb_bits),
        .fb_words(fb_words), .txd(txd), .run_mode(run_mode), .wr(wr), .cfg_act(cfg_act));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // counted at the falling edge, away from the edge that launches the one-cycle strobe
    always @(negedge clk_sys) if (wr.stb === 1'b1) stb_cnt++;
    // -------------------------------------------------------------------------
    // checking and closing
    // -------------------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    // -------------------------------------------------------------------------
    // stimulus helpers
    // -------------------------------------------------------------------------
    task automatic do_reset(input bsl_cfg_s c);
        @(negedge clk_sys);
        cur = c;
        cfg_nv = c;
        rst_n = 1'b0;
        repeat (10) @(negedge clk_sys);
        check("txd in reset", 16'h0001, {15'h0, txd});
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        check("settings in force", {10'h0, cur}, {10'h0, cfg_act});
        check("mode after reset", 16'h0000, {15'h0, run_mode});
    endtask : do_reset
    // one request frame; the expected reply is worked out here from the settings in force
    task automatic xfer(input logic [7:0] stn, cmd, adr, input logic [15:0] d);
        logic [7:0] lim;
        logic err;
        logic go;
        logic wr_ok;
        logic [15:0] v;
        int s0;
        @(negedge clk_sys);
        dev_bits = {$urandom, $urandom};
        fb_bits = MAP_MAX'({$urandom, $urandom, $urandom, $urandom});
        foreach (fb_words[i]) fb_words[i] = 16'($urandom);
        lim = (cur.mem == MEM_50) ? MAP_50 : (cur.mem == MEM_100) ? MAP_100 : MAP_0;
        v = d;
        case (cmd)
            CMD_RD_DEV, CMD_WR_DEV: err = (adr >= 8'h40);
            CMD_RD_FBB, CMD_WR_FBB, CMD_RD_FBW, CMD_WR_FBW: err = (adr >= lim);
            CMD_LINE, CMD_RUNSTOP, CMD_TS_SET: err = 1'b0;
            default: err = 1'b1;
        endcase
        if (cmd == CMD_RD_DEV) v = {15'h0, dev_bits[adr[5:0]]};
        if (cmd == CMD_RD_FBB && !err) v = {15'h0, fb_bits[adr]};
        if (cmd == CMD_RD_FBW && !err) v = fb_words[adr];
        if (err) v = 16'h0000;
        go = (stn === {4'h0, cur.station}) && (hs_ok === 1'b1);
        exp_q.delete();
        if (go && cmd == CMD_RUNSTOP) exp_q = '{STX, FLAG_DONE, STX, ACK};
        else if (go) exp_q = '{STX, stn, err ? (cmd | ERR_MARK) : cmd, adr, v[15:8], v[7:0], ETX};
        host.rx_q.delete();
        s0 = stb_cnt;
        host.send_frame(stn, cmd, adr, d[15:8], d[7:0]);
        for (int n = 0; n < 1500 && (go == 1'b0 || host.rx_q.size() < exp_q.size()); n++) begin
            @(negedge clk_sys);
        end
        // longer than one character, so a surplus reply byte is seen before the length check
        repeat (12 * BITC) @(negedge clk_sys);
        check("reply length", 16'(exp_q.size()), 16'(host.rx_q.size()));
        for (int i = 0; i < exp_q.size() && i < host.rx_q.size(); i++) begin
            check("reply byte", {8'h0, exp_q[i]}, {8'h0, host.rx_q[i]});
        end
        if (go && cmd == CMD_RUNSTOP) check("run mode", {15'h0, d[0]}, {15'h0, run_mode});
        wr_ok = go && !err && (cmd inside {CMD_WR_DEV, CMD_WR_FBB, CMD_WR_FBW, CMD_TS_SET});
        check("write strobes", {15'h0, wr_ok}, 16'(stb_cnt - s0));
        if (wr_ok) check("write data", d, wr.data);
        if (wr_ok) check("write address", {cmd, adr}, {wr.cmd, wr.addr});
    endtask : xfer
    // -------------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        cfg_nv = '0;
        dev_bits = '0;
        fb_bits = '0;
        fb_words = '0;
        void'($urandom(32'hbf75));
        do_reset('{station: 4'($urandom), mem: MEM_50});
        repeat (300) @(negedge clk_sys);
        check("unsolicited bytes", 16'h0000, 16'(host.rx_q.size()));
        $display("test reset done");
        for (int c = 0; c <= 9; c++) begin
            xfer({4'h0, cur.station}, 8'(c), 8'($urandom_range(0, 49)), 16'($urandom));
        end
        xfer({4'h0, cur.station}, CMD_RUNSTOP, 8'h00, 16'h0000);
        xfer({4'h0, cur.station}, CMD_RUNSTOP, 8'h00, 16'h0001);
        foreach (corners[i]) xfer({4'h0, cur.station}, corners[i][15:8], corners[i][7:0], 16'h5aa5);
        $display("test commands done");
        xfer({4'h0, cur.station ^ 4'h1}, CMD_LINE, 8'h11, 16'h2233);
        @(negedge clk_sys);
        host.hs_ok = 1'b0;
        xfer({4'h0, cur.station}, CMD_LINE, 8'h11, 16'h2233);
        host.hs_ok = 1'b1;
        $display("test refusals done");
        cfg_nv = '{station: 4'hf, mem: MEM_NONE};
        repeat (20) @(negedge clk_sys);
        check("settings held", {10'h0, cur}, {10'h0, cfg_act});
        do_reset('{station: 4'hf, mem: MEM_NONE});
        xfer(8'h0f, CMD_RD_FBB, 8'h00, 16'h0000);
        xfer(8'h0f, CMD_LINE, 8'hff, 16'hffff);
        do_reset('{station: 4'h0, mem: MEM_100});
        xfer(8'h00, CMD_RD_FBW, 8'h63, 16'h0000);
        xfer(8'h00, CMD_RD_FBB, 8'h64, 16'h0000);
        $display("test settings done");
        summarize();
    end
    initial begin
        repeat (95000) @(posedge clk_sys);
        num_errors++;
        $display("watchdog expired");
        summarize();
    end
endmodule : tb_top
`default_nettype wire
